//--- core/bpu_regs.svh
// Constants of the branch and predication unit
`ifndef BPU_REGS_SVH
`define BPU_REGS_SVH
`define BPU_REG_LINK 4'he
`define BPU_REG_SP 4'hd
`define BPU_REG_PC 4'hf
`define BPU_LOW_REG_MAX 4'h7
`define BPU_COND_ALWAYS 4'he
`define BPU_COND_NEVER 4'hf
`define BPU_MAX_SLOTS 3'h4
`define BPU_NARROW_SIGN 19
`define BPU_PC_READ_OFS 32'h00000004
`define BPU_WIDE_LEN 32'h00000004
`define BPU_NARROW_LEN 32'h00000002
`define BPU_STATE_W 11
`endif

//--- core/bpu_pkg.sv
// Types shared by the branch and predication unit
`default_nettype none
package bpu_pkg;
  typedef enum logic [3:0] {
    OP_OTHER = 4'h0,
    OP_BRANCH = 4'h1,
    OP_CALL_IMMEDIATE = 4'h2,
    OP_JUMP_REGISTER = 4'h3,
    OP_CALL_REGISTER = 4'h4,
    OP_COMPARE_ZERO_JUMP = 4'h5,
    OP_COMPARE_NONZERO_JUMP = 4'h6,
    OP_PREDICATE_PREFIX = 4'h7,
    OP_TABLE_JUMP_BYTE = 4'h8,
    OP_TABLE_JUMP_HALF = 4'h9,
    OP_BREAKPOINT_TRAP = 4'ha,
    OP_MASK_OP = 4'hb,
    OP_PC_WRITE = 4'hc
  } op_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_TABLE = 2'b10
  } state_t;
endpackage
`default_nettype wire

//--- core/branch_and_predication_unit.sv
// Branch resolution and predicated-block control for the core
`include "bpu_regs.svh"
`default_nettype none
// Behaviour
// - register jump target has bit 0 cleared
// - calls write next address to link register
// - register jump with even target faults
// - wide offsets 16 MB, outside conditional 1 MB
// - only plain branch conditional outside block
// - compare jumps test zero, flags untouched
// - compare jumps use low registers only
// - compare jump target 4 to 130 forward
// - prefix makes one to four slots conditional
// - always-prefix allows no else slots
// - breakpoint in block always executes
// - exceptions allowed between and inside slots
// - exception return restores remaining slots
// - table base register, PC base follows instruction
// - half table index shifted left one
// - table entry doubled, forward from next instruction
// - no instruction here alters condition flags
module branch_and_predication_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Decoded instruction
  input wire logic instr_valid_i,
  input wire bpu_pkg::op_t op_i,
  input wire logic [3:0] cond_i,
  input wire logic wide_i,
  input wire logic [31:0] pc_i,
  input wire logic [23:0] imm_i,
  input wire logic [3:0] reg_num_i,
  input wire logic [31:0] reg_val_i,
  input wire logic [3:0] base_num_i,
  input wire logic [31:0] base_val_i,
  input wire logic [2:0] pf_count_i,
  input wire logic [2:0] pf_else_i,
  input wire logic [3:0] flags_i,
  // Table read port
  input wire logic table_ack_i,
  input wire logic [15:0] table_data_i,
  output logic table_req_o,
  output logic table_half_o,
  output logic [31:0] table_addr_o,
  // Exception interface
  input wire logic exc_entry_i,
  input wire logic exc_return_i,
  input wire logic [`BPU_STATE_W-1:0] ret_state_i,
  output logic [`BPU_STATE_W-1:0] it_state_o,
  // Results
  output logic busy_o,
  output logic exec_o,
  output logic branch_o,
  output logic [31:0] branch_target_o,
  output logic link_we_o,
  output logic [31:0] link_data_o,
  output logic fault_o,
  output logic debug_o,
  output logic illegal_o
);

  // ----------------------------------------------------------------
  // Condition evaluation
  // ----------------------------------------------------------------
  // Flags are only read here, never written back
  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic r;
    r = 1'b1;
    case (c[3:1])
      3'h0: r = f[2];
      3'h1: r = f[1];
      3'h2: r = f[3];
      3'h3: r = f[0];
      3'h4: r = f[1] & ~f[2];
      3'h5: r = (f[3] == f[0]);
      3'h6: r = (f[3] == f[0]) & ~f[2];
      default: r = 1'b1;
    endcase
    if (c[0] && (c != `BPU_COND_NEVER))
    begin
      r = ~r;
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bpu_pkg::state_t state_q, state_d;
  logic [3:0] it_cond_q, it_cond_d;
  logic [2:0] it_cnt_q, it_cnt_d;
  logic [3:0] it_inv_q, it_inv_d;
  logic [31:0] tpc_q, tpc_d;
  logic thalf_q, thalf_d;
  logic treq_q, treq_d;
  logic [31:0] taddr_q, taddr_d;
  logic busy_q, busy_d;
  logic exec_q, exec_d;
  logic branch_q, branch_d;
  logic [31:0] target_q, target_d;
  logic link_we_q, link_we_d;
  logic [31:0] link_q, link_d;
  logic fault_q, fault_d;
  logic debug_q, debug_d;
  logic illegal_q, illegal_d;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic go, in_blk, last_slot, pc_writer, pass, ill, do_it;
  logic [3:0] slot_cond, eff_cond;
  logic [31:0] pc_rd, nxt, off_wide, off_narrow, off_cz, tbase, tidx;
  logic [15:0] entry;

  // Accept only while idle; an exception event owns the cycle
  assign go = instr_valid_i && (state_q == bpu_pkg::ST_IDLE) && !exc_entry_i && !exc_return_i;
  assign in_blk = (it_cnt_q != 3'h0);
  assign last_slot = (it_cnt_q == 3'h1);
  assign slot_cond = {it_cond_q[3:1], it_cond_q[0] ^ it_inv_q[0]};
  assign pc_writer = (op_i == bpu_pkg::OP_BRANCH) || (op_i == bpu_pkg::OP_CALL_IMMEDIATE) ||
                     (op_i == bpu_pkg::OP_JUMP_REGISTER) || (op_i == bpu_pkg::OP_CALL_REGISTER) ||
                     (op_i == bpu_pkg::OP_TABLE_JUMP_BYTE) ||
                     (op_i == bpu_pkg::OP_TABLE_JUMP_HALF) || (op_i == bpu_pkg::OP_PC_WRITE);
  // Outside a block only the plain branch carries its own condition
  assign eff_cond = in_blk ? slot_cond :
                    ((op_i == bpu_pkg::OP_BRANCH) ? cond_i : `BPU_COND_ALWAYS);
  assign pass = cond_ok(eff_cond, flags_i);
  assign pc_rd = pc_i + `BPU_PC_READ_OFS;
  assign nxt = pc_i + (wide_i ? `BPU_WIDE_LEN : `BPU_NARROW_LEN);
  // Halfword offsets: 24 bits give 16 MB, 20 bits give 1 MB
  assign off_wide = {{7{imm_i[23]}}, imm_i, 1'b0};
  assign off_narrow = {{11{imm_i[`BPU_NARROW_SIGN]}}, imm_i[19:0], 1'b0};
  assign off_cz = {25'h0000000, imm_i[5:0], 1'b0};
  assign tbase = (base_num_i == `BPU_REG_PC) ? nxt : base_val_i;
  assign tidx = (op_i == bpu_pkg::OP_TABLE_JUMP_HALF) ?
                {reg_val_i[30:0], 1'b0} : reg_val_i;
  assign entry = thalf_q ? table_data_i : {8'h00, table_data_i[7:0]};

  // Legality screen; the offending instruction is squashed, except that a breakpoint still pulses debug
  always_comb
  begin
    ill = 1'b0;
    if (in_blk && ((op_i == bpu_pkg::OP_PREDICATE_PREFIX) || (op_i == bpu_pkg::OP_MASK_OP) ||
        (op_i == bpu_pkg::OP_COMPARE_ZERO_JUMP) || (op_i == bpu_pkg::OP_COMPARE_NONZERO_JUMP)))
    begin
      ill = 1'b1;
    end
    if (in_blk && pc_writer && !last_slot)
    begin
      ill = 1'b1;
    end
    if (in_blk && (op_i != bpu_pkg::OP_BREAKPOINT_TRAP) && (cond_i != slot_cond))
    begin
      ill = 1'b1;
    end
    if (!in_blk && (op_i != bpu_pkg::OP_BRANCH) && (op_i != bpu_pkg::OP_PREDICATE_PREFIX) &&
        (cond_i != `BPU_COND_ALWAYS))
    begin
      ill = 1'b1;
    end
    if ((op_i == bpu_pkg::OP_PREDICATE_PREFIX) && ((pf_count_i == 3'h0) ||
        (pf_count_i > `BPU_MAX_SLOTS) ||
        ((cond_i == `BPU_COND_ALWAYS) && (pf_else_i != 3'h0))))
    begin
      ill = 1'b1;
    end
    if (((op_i == bpu_pkg::OP_COMPARE_ZERO_JUMP) || (op_i == bpu_pkg::OP_COMPARE_NONZERO_JUMP))
        && (reg_num_i > `BPU_LOW_REG_MAX))
    begin
      ill = 1'b1;
    end
    if (((op_i == bpu_pkg::OP_TABLE_JUMP_BYTE) || (op_i == bpu_pkg::OP_TABLE_JUMP_HALF)) &&
        ((reg_num_i == `BPU_REG_SP) || (reg_num_i == `BPU_REG_PC) ||
        (base_num_i == `BPU_REG_SP)))
    begin
      ill = 1'b1;
    end
    if ((op_i == bpu_pkg::OP_CALL_REGISTER) && (reg_num_i == `BPU_REG_PC))
    begin
      ill = 1'b1;
    end
  end

  assign do_it = go && !ill && pass;

  // ----------------------------------------------------------------
  // Predication state
  // ----------------------------------------------------------------
  // Restore wins over entry so a nested return cannot lose slots
  always_comb
  begin
    it_cond_d = it_cond_q;
    it_cnt_d = it_cnt_q;
    it_inv_d = it_inv_q;
    if (exc_return_i)
    begin
      {it_cond_d, it_cnt_d, it_inv_d} = ret_state_i;
    end
    else if (exc_entry_i)
    begin
      it_cond_d = 4'h0;
      it_cnt_d = 3'h0;
      it_inv_d = 4'h0;
    end
    else if (go && (op_i == bpu_pkg::OP_PREDICATE_PREFIX) && !in_blk && !ill)
    begin
      it_cond_d = cond_i;
      it_cnt_d = pf_count_i;
      it_inv_d = {pf_else_i, 1'b0};
    end
    else if (go && in_blk)
    begin
      it_cnt_d = it_cnt_q - 3'h1;
      it_inv_d = {1'b0, it_inv_q[3:1]};
      if (last_slot)
      begin
        it_cond_d = 4'h0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      it_cond_q <= 4'h0;
      it_cnt_q <= 3'h0;
      it_inv_q <= 4'h0;
    end
    else
    begin
      it_cond_q <= it_cond_d;
      it_cnt_q <= it_cnt_d;
      it_inv_q <= it_inv_d;
    end
  end

  // ----------------------------------------------------------------
  // Branch resolution and table walk
  // ----------------------------------------------------------------
  // Results are one-cycle pulses; a table read holds off new work
  always_comb
  begin
    state_d = state_q;
    tpc_d = tpc_q;
    thalf_d = thalf_q;
    taddr_d = taddr_q;
    treq_d = 1'b0;
    exec_d = go && !ill && pass;
    branch_d = 1'b0;
    target_d = target_q;
    link_we_d = 1'b0;
    link_d = link_q;
    fault_d = 1'b0;
    debug_d = go && (op_i == bpu_pkg::OP_BREAKPOINT_TRAP);
    illegal_d = go && ill;
    unique case (state_q)
      bpu_pkg::ST_IDLE:
      begin
        if (do_it)
        begin
          unique case (op_i)
            bpu_pkg::OP_BRANCH:
            begin
              branch_d = 1'b1;
              target_d = pc_rd + ((in_blk || (cond_i == `BPU_COND_ALWAYS)) ?
                         off_wide : off_narrow);
            end
            bpu_pkg::OP_CALL_IMMEDIATE:
            begin
              branch_d = 1'b1;
              target_d = pc_rd + off_wide;
              link_we_d = 1'b1;
              link_d = nxt;
            end
            bpu_pkg::OP_JUMP_REGISTER, bpu_pkg::OP_CALL_REGISTER:
            begin
              if (!reg_val_i[0])
              begin
                fault_d = 1'b1;
              end
              else
              begin
                branch_d = 1'b1;
                target_d = {reg_val_i[31:1], 1'b0};
                link_we_d = (op_i == bpu_pkg::OP_CALL_REGISTER);
                link_d = nxt;
              end
            end
            bpu_pkg::OP_COMPARE_ZERO_JUMP, bpu_pkg::OP_COMPARE_NONZERO_JUMP:
            begin
              branch_d = (reg_val_i == 32'h00000000) ==
                         (op_i == bpu_pkg::OP_COMPARE_ZERO_JUMP);
              target_d = pc_rd + off_cz;
            end
            bpu_pkg::OP_TABLE_JUMP_BYTE, bpu_pkg::OP_TABLE_JUMP_HALF:
            begin
              state_d = bpu_pkg::ST_TABLE;
              treq_d = 1'b1;
              taddr_d = tbase + tidx;
              thalf_d = (op_i == bpu_pkg::OP_TABLE_JUMP_HALF);
              tpc_d = nxt;
            end
            default:
            begin
              branch_d = 1'b0;
            end
          endcase
        end
      end
      bpu_pkg::ST_TABLE:
      begin
        if (table_ack_i)
        begin
          state_d = bpu_pkg::ST_IDLE;
          branch_d = 1'b1;
          target_d = tpc_q + {15'h0000, entry, 1'b0};
        end
      end
      default:
      begin
        state_d = bpu_pkg::ST_IDLE;
      end
    endcase
    busy_d = (state_d != bpu_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q <= bpu_pkg::ST_IDLE;
      tpc_q <= 32'h00000000;
      thalf_q <= 1'b0;
      treq_q <= 1'b0;
      taddr_q <= 32'h00000000;
      busy_q <= 1'b0;
      exec_q <= 1'b0;
      branch_q <= 1'b0;
      target_q <= 32'h00000000;
      link_we_q <= 1'b0;
      link_q <= 32'h00000000;
      fault_q <= 1'b0;
      debug_q <= 1'b0;
      illegal_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      tpc_q <= tpc_d;
      thalf_q <= thalf_d;
      treq_q <= treq_d;
      taddr_q <= taddr_d;
      busy_q <= busy_d;
      exec_q <= exec_d;
      branch_q <= branch_d;
      target_q <= target_d;
      link_we_q <= link_we_d;
      link_q <= link_d;
      fault_q <= fault_d;
      debug_q <= debug_d;
      illegal_q <= illegal_d;
    end
  end

  // Outputs straight from flops
  assign table_req_o = treq_q;
  assign table_half_o = thalf_q;
  assign table_addr_o = taddr_q;
  assign it_state_o = {it_cond_q, it_cnt_q, it_inv_q};
  assign busy_o = busy_q;
  assign exec_o = exec_q;
  assign branch_o = branch_q;
  assign branch_target_o = target_q;
  assign link_we_o = link_we_q;
  assign link_data_o = link_q;
  assign fault_o = fault_q;
  assign debug_o = debug_q;
  assign illegal_o = illegal_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reg_target_even: assert property (branch_o |-> !branch_target_o[0])
    else $error("branch target has bit 0 set");
  a_call_link: assert property (do_it && (op_i == bpu_pkg::OP_CALL_IMMEDIATE) |=>
    link_we_o && branch_o && (link_data_o == $past(nxt)))
    else $error("call did not write next address to link");
  a_even_faults: assert property (do_it && (op_i == bpu_pkg::OP_JUMP_REGISTER) &&
    !reg_val_i[0] |=> fault_o && !branch_o && !link_we_o)
    else $error("even register target did not fault");
  a_narrow_reach: assert property (do_it && (op_i == bpu_pkg::OP_BRANCH) && !in_blk &&
    (cond_i != `BPU_COND_ALWAYS) |=>
    (branch_target_o - $past(pc_rd)) == $past(off_narrow))
    else $error("outside conditional branch used wide offset");
  a_outside_cond: assert property (go && !in_blk && (op_i == bpu_pkg::OP_CALL_IMMEDIATE) &&
    (cond_i != `BPU_COND_ALWAYS) |=> illegal_o && !branch_o)
    else $error("conditional call outside block accepted");
  a_cz_window: assert property (do_it && (op_i == bpu_pkg::OP_COMPARE_ZERO_JUMP) |=>
    (branch_o == ($past(reg_val_i) == 32'h00000000)) &&
    ((branch_target_o - $past(pc_i)) >= 32'h4) &&
    ((branch_target_o - $past(pc_i)) <= 32'h82))
    else $error("compare jump outcome or window wrong");
  a_cz_low_reg: assert property (go && ((op_i == bpu_pkg::OP_COMPARE_ZERO_JUMP) ||
    (op_i == bpu_pkg::OP_COMPARE_NONZERO_JUMP)) && (reg_num_i > `BPU_LOW_REG_MAX) |=>
    illegal_o && !branch_o)
    else $error("high register compare jump accepted");
  a_slot_limit: assert property (it_cnt_q <= `BPU_MAX_SLOTS)
    else $error("more than four slots pending");
  a_always_no_else: assert property (go && (op_i == bpu_pkg::OP_PREDICATE_PREFIX) &&
    !in_blk && (cond_i == `BPU_COND_ALWAYS) && (pf_else_i != 3'h0) |=>
    (it_cnt_q == 3'h0) && illegal_o)
    else $error("always prefix with else slot accepted");
  a_breakpoint_trap_always: assert property (go && (op_i == bpu_pkg::OP_BREAKPOINT_TRAP) |=> debug_o)
    else $error("breakpoint did not enter debug");
  a_exc_clears: assert property (exc_entry_i && !exc_return_i |=> it_cnt_q == 3'h0)
    else $error("exception entry left block active");
  a_exc_restore: assert property (exc_return_i |=> it_state_o == $past(ret_state_i))
    else $error("exception return did not restore slots");
  a_half_index: assert property (do_it && (op_i == bpu_pkg::OP_TABLE_JUMP_HALF) |=>
    table_req_o && table_half_o && busy_o &&
    (table_addr_o == $past(tbase) + {$past(reg_val_i[30:0]), 1'b0}))
    else $error("half table address wrong");
  a_table_target: assert property ((state_q == bpu_pkg::ST_TABLE) && table_ack_i |=>
    branch_o && !busy_o &&
    (branch_target_o == $past(tpc_q) + {15'h0000, $past(entry), 1'b0}))
    else $error("table target wrong");
  a_block_ends: assert property (go && last_slot |=> it_cnt_q == 3'h0)
    else $error("block did not end after last slot");

  c_four_slots: cover property (go && (op_i == bpu_pkg::OP_PREDICATE_PREFIX) &&
    (pf_count_i == `BPU_MAX_SLOTS) && !ill);
  c_table_taken: cover property ((state_q == bpu_pkg::ST_TABLE) && table_ack_i);
  c_reg_fault: cover property (fault_o);
  c_exc_mid_block: cover property (exc_entry_i && in_blk ##[1:20] exc_return_i);

endmodule
`default_nettype wire

//--- tb/table_mem_model.sv
// Data memory model that answers the unit's table entry reads
`default_nettype none
module table_mem_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Table read port
  input wire logic table_req_i,
  input wire logic table_half_i,
  input wire logic [31:0] table_addr_i,
  input wire logic [3:0] delay_i,
  output logic table_ack_o,
  output logic [15:0] table_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pend_q;
  logic half_q;
  logic [31:0] addr_q;
  logic [3:0] wait_q;
  logic [15:0] word;

  // Entry contents depend on the address only
  assign word = addr_q[15:0] ^ 16'h9c35;

  // Answer after a chosen number of cycles; data bus toggles when idle
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pend_q <= 1'b0;
      half_q <= 1'b0;
      addr_q <= 32'h0;
      wait_q <= 4'h0;
      table_ack_o <= 1'b0;
      table_data_o <= 16'h0;
    end
    else
    begin
      table_ack_o <= 1'b0;
      table_data_o <= ~table_data_o;
      if (pend_q && wait_q == 4'h0)
      begin
        table_ack_o <= 1'b1;
        // Upper byte is junk on byte reads, so it must be ignored
        table_data_o <= half_q ? word : {~word[15:8], word[7:0]};
        pend_q <= 1'b0;
      end
      else if (pend_q)
      begin
        wait_q <= wait_q - 4'h1;
      end
      else if (table_req_i)
      begin
        pend_q <= 1'b1;
        half_q <= table_half_i;
        addr_q <= table_addr_i;
        wait_q <= delay_i;
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/branch_and_predication_unit_tb_top.sv
// Self-checking bench for the branch and predication unit
`include "bpu_regs.svh"
`default_nettype none
module branch_and_predication_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  bpu_pkg::op_t op_i = bpu_pkg::OP_OTHER;
  logic [3:0] cond_i = 4'he;
  logic wide_i = 1'b0;
  logic [31:0] pc_i = 32'h0;
  logic [23:0] imm_i = 24'h0;
  logic [3:0] reg_num_i = 4'h0;
  logic [31:0] reg_val_i = 32'h0;
  logic [3:0] base_num_i = 4'h0;
  logic [31:0] base_val_i = 32'h0;
  logic [2:0] pf_count_i = 3'h1;
  logic [2:0] pf_else_i = 3'h0;
  logic [3:0] flags_i = 4'h0;
  logic exc_entry_i = 1'b0;
  logic exc_return_i = 1'b0;
  logic [`BPU_STATE_W-1:0] ret_state_i = 11'h0;
  logic [3:0] delay = 4'h0;
  logic table_ack_i, table_req_o, table_half_o, busy_o, exec_o, branch_o;
  logic link_we_o, fault_o, debug_o, illegal_o;
  logic [15:0] table_data_i;
  logic [31:0] table_addr_o, branch_target_o, link_data_o;
  logic [`BPU_STATE_W-1:0] it_state_o;
  integer seed = 32'hd0a3;
  int fails = 0;
  int check_count = 0;

  // Free-running 100 MHz clock
  always #5 clk_i = ~clk_i;

  branch_and_predication_unit dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .op_i(op_i), .cond_i(cond_i), .wide_i(wide_i),
    .pc_i(pc_i), .imm_i(imm_i), .reg_num_i(reg_num_i), .reg_val_i(reg_val_i),
    .base_num_i(base_num_i), .base_val_i(base_val_i), .pf_count_i(pf_count_i),
    .pf_else_i(pf_else_i), .flags_i(flags_i), .table_ack_i(table_ack_i),
    .table_data_i(table_data_i), .table_req_o(table_req_o), .table_half_o(table_half_o),
    .table_addr_o(table_addr_o), .exc_entry_i(exc_entry_i), .exc_return_i(exc_return_i),
    .ret_state_i(ret_state_i), .it_state_o(it_state_o), .busy_o(busy_o), .exec_o(exec_o),
    .branch_o(branch_o), .branch_target_o(branch_target_o), .link_we_o(link_we_o),
    .link_data_o(link_data_o), .fault_o(fault_o), .debug_o(debug_o), .illegal_o(illegal_o));

  table_mem_model mem_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .table_req_i(table_req_o),
    .table_half_i(table_half_o), .table_addr_i(table_addr_o), .delay_i(delay),
    .table_ack_o(table_ack_i), .table_data_o(table_data_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] sx24(input logic [23:0] i);
    return {{7{i[23]}}, i, 1'b0};
  endfunction

  function automatic logic [31:0] sx20(input logic [23:0] i);
    return {{11{i[19]}}, i[19:0], 1'b0};
  endfunction

  task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Present one instruction at a falling edge; returns when its answer is visible
  task automatic issue(input bpu_pkg::op_t op, input logic [3:0] cond, input logic [31:0] pc,
                       input logic [23:0] imm, input logic [3:0] rn, input logic [31:0] rv);
    // Gap cycle, so valid never falls and rises in one step
    @(negedge clk_i);
    op_i = op;
    cond_i = cond;
    pc_i = pc;
    imm_i = imm;
    reg_num_i = rn;
    reg_val_i = rv;
    instr_valid_i = 1'b1;
    @(negedge clk_i);
    instr_valid_i = 1'b0;
  endtask

  // Pulses packed as branch, link, fault, debug, illegal
  task automatic outs(input logic [4:0] e, input logic [31:0] tgt, input logic [31:0] lnk);
    chk_val("pulses", {27'h0, e}, {27'h0, branch_o, link_we_o, fault_o, debug_o, illegal_o});
    if (e[4])
      chk_val("target", tgt, branch_target_o);
    if (e[3])
      chk_val("link", lnk, link_data_o);
  endtask

  task automatic slots(input logic [2:0] n);
    chk_val("slots left", {29'h0, n}, {29'h0, it_state_o[6:4]});
  endtask

  task automatic exc(input logic ent, input logic ret, input logic [10:0] rs);
    @(negedge clk_i);
    exc_entry_i = ent;
    exc_return_i = ret;
    ret_state_i = rs;
    @(negedge clk_i);
    exc_entry_i = 1'b0;
    exc_return_i = 1'b0;
  endtask

  // Table branch, answered after dl extra cycles by the memory model
  task automatic tbl(input logic half, input logic [3:0] bn, input logic [31:0] bv,
                     input logic [31:0] idx, input logic [3:0] dl);
    logic [31:0] addr;
    logic [15:0] w;
    logic [31:0] ent;
    int n;
    addr = ((bn == `BPU_REG_PC) ? 32'h1000 + 32'h4 : bv) + (half ? idx << 1 : idx);
    w = addr[15:0] ^ 16'h9c35;
    ent = half ? {16'h0, w} : {24'h0, w[7:0]};
    delay = dl;
    base_num_i = bn;
    base_val_i = bv;
    wide_i = 1'b1;
    issue(half ? bpu_pkg::OP_TABLE_JUMP_HALF : bpu_pkg::OP_TABLE_JUMP_BYTE, 4'he,
          32'h1000, 24'h0, 4'h2, idx);
    chk_val("table request", 32'h1, {31'h0, table_req_o});
    chk_val("table address", addr, table_addr_o);
    chk_val("table busy", 32'h1, {31'h0, busy_o});
    chk_val("table half", {31'h0, half}, {31'h0, table_half_o});
    n = 0;
    while (branch_o !== 1'b1 && n < 40)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_val("table branch", 32'h1, {31'h0, branch_o});
    chk_val("table idle", 32'h0, {31'h0, busy_o});
    chk_val("table target", 32'h1004 + {ent[30:0], 1'b0}, branch_target_o);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the whole run takes well under a thousand cycles
  initial
  begin
    #200000;
    fails++;
    close_out();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] r, pc, rv;
    logic [23:0] imm;
    repeat (3) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    // Random unconditional branches, calls and register jumps
    for (int i = 0; i < 24; i++)
    begin
      r = $random(seed);
      pc = $random(seed) & 32'hfffffffe;
      rv = $random(seed);
      imm = 24'($random(seed));
      wide_i = ~r[1];
      if (r[1:0] == 2'h0)
      begin
        issue(bpu_pkg::OP_CALL_IMMEDIATE, 4'he, pc, imm, 4'h0, rv);
        outs(5'b11000, pc + 32'h4 + sx24(imm), pc + 32'h4);
      end
      else if (r[1:0] == 2'h1)
      begin
        issue(bpu_pkg::OP_BRANCH, 4'he, pc, imm, 4'h0, rv);
        outs(5'b10000, pc + 32'h4 + sx24(imm), 32'h0);
      end
      else
      begin
        issue(r[0] ? bpu_pkg::OP_CALL_REGISTER : bpu_pkg::OP_JUMP_REGISTER, 4'he, pc, imm,
              4'h3, rv);
        if (rv[0])
          outs({1'b1, r[0], 3'b000}, rv & 32'hfffffffe, pc + 32'h2);
        else
          outs(5'b00100, 32'h0, 32'h0);
      end
    end
    $display("test random branches done");
    // Conditional branch outside a block, and a conditional call there
    flags_i = 4'h4;
    wide_i = 1'b1;
    issue(bpu_pkg::OP_BRANCH, 4'h0, 32'h2000, 24'h9a0b3c, 4'h0, 32'h0);
    outs(5'b10000, 32'h2004 + sx20(24'h9a0b3c), 32'h0);
    issue(bpu_pkg::OP_BRANCH, 4'h1, 32'h2000, 24'h000010, 4'h0, 32'h0);
    outs(5'b00000, 32'h0, 32'h0);
    issue(bpu_pkg::OP_CALL_IMMEDIATE, 4'h0, 32'h2000, 24'h000010, 4'h0, 32'h0);
    outs(5'b00001, 32'h0, 32'h0);
    $display("test conditional branches done");
    // Compare jumps at both ends of the forward window, then a high register
    wide_i = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      rv = k[0] ? 32'h0 : 32'h80;
      issue(k[1] ? bpu_pkg::OP_COMPARE_NONZERO_JUMP : bpu_pkg::OP_COMPARE_ZERO_JUMP, 4'he,
            32'h3000, k[2] ? 24'h3f : 24'h0, 4'h7, rv);
      outs({k[0] ^ k[1], 4'b0000}, 32'h3004 + (k[2] ? 32'h7e : 32'h0), 32'h0);
    end
    issue(bpu_pkg::OP_COMPARE_ZERO_JUMP, 4'he, 32'h3000, 24'h4, 4'h8, 32'h0);
    outs(5'b00001, 32'h0, 32'h0);
    $display("test compare jumps done");
    // Block of two slots, the last one a wide-reach else branch
    pf_count_i = 3'h2;
    pf_else_i = 3'h1;
    issue(bpu_pkg::OP_PREDICATE_PREFIX, 4'h0, 32'h4000, 24'h0, 4'h0, 32'h0);
    slots(3'h2);
    issue(bpu_pkg::OP_OTHER, 4'h0, 32'h4002, 24'h0, 4'h0, 32'h0);
    chk_val("exec", 32'h1, {31'h0, exec_o});
    slots(3'h1);
    flags_i = 4'h0;
    wide_i = 1'b1;
    issue(bpu_pkg::OP_BRANCH, 4'h1, 32'h4004, 24'h9a0b3c, 4'h0, 32'h0);
    outs(5'b10000, 32'h4008 + sx24(24'h9a0b3c), 32'h0);
    slots(3'h0);
    // Breakpoint whose slot condition fails
    pf_count_i = 3'h1;
    issue(bpu_pkg::OP_PREDICATE_PREFIX, 4'h0, 32'h4100, 24'h0, 4'h0, 32'h0);
    issue(bpu_pkg::OP_BREAKPOINT_TRAP, 4'h0, 32'h4102, 24'h0, 4'h0, 32'h0);
    outs(5'b00010, 32'h0, 32'h0);
    // Refused forms inside a block
    pf_count_i = 3'h2;
    issue(bpu_pkg::OP_PREDICATE_PREFIX, 4'h0, 32'h4180, 24'h0, 4'h0, 32'h0);
    issue(bpu_pkg::OP_COMPARE_ZERO_JUMP, 4'he, 32'h4182, 24'h4, 4'h1, 32'h0);
    outs(5'b00001, 32'h0, 32'h0);
    issue(bpu_pkg::OP_OTHER, 4'h3, 32'h4184, 24'h0, 4'h0, 32'h0);
    outs(5'b00001, 32'h0, 32'h0);
    // Always-prefix with an else slot
    pf_count_i = 3'h2;
    issue(bpu_pkg::OP_PREDICATE_PREFIX, 4'he, 32'h4200, 24'h0, 4'h0, 32'h0);
    outs(5'b00001, 32'h0, 32'h0);
    exc(1'b1, 1'b0, 11'h0);
    $display("test predicated blocks done");
    // Exception inside a block, then return into its middle
    flags_i = 4'h4;
    pf_count_i = 3'h4;
    pf_else_i = 3'h0;
    issue(bpu_pkg::OP_PREDICATE_PREFIX, 4'h0, 32'h5000, 24'h0, 4'h0, 32'h0);
    slots(3'h4);
    exc(1'b1, 1'b0, 11'h0);
    slots(3'h0);
    exc(1'b0, 1'b1, {4'h0, 3'h2, 4'b0010});
    chk_val("restored state", {21'h0, 4'h0, 3'h2, 4'b0010}, {21'h0, it_state_o});
    issue(bpu_pkg::OP_OTHER, 4'h0, 32'h5004, 24'h0, 4'h0, 32'h0);
    chk_val("exec", 32'h1, {31'h0, exec_o});
    issue(bpu_pkg::OP_OTHER, 4'h1, 32'h5006, 24'h0, 4'h0, 32'h0);
    chk_val("exec", 32'h0, {31'h0, exec_o});
    slots(3'h0);
    $display("test exception in block done");
    // Table branches, byte and half, PC base and register base, prompt and slow
    tbl(1'b0, `BPU_REG_PC, 32'h0, 32'h5, 4'h0);
    tbl(1'b1, `BPU_REG_PC, 32'h0, 32'h7, 4'h3);
    tbl(1'b0, 4'h1, 32'h8000, 32'hff, 4'h5);
    tbl(1'b1, 4'h1, 32'h8100, 32'h33, 4'h0);
    $display("test table branches done");
    close_out();
  end
endmodule
`default_nettype wire
